// *** rtl/phy_loopback_reset_config.sv ***
// upper fields of phy general config register 1: loopback, vt inhibit, macro reset, zclk
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_map.svh"
module phy_loopback_reset_config
  import phy_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register bus
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  // phy side inputs
  input  wire logic [7:0]  sw_rdqs_delay,
  input  wire logic        init_done,
  // loopback steering
  output logic             loopback_enable,
  output logic      [1:0]  loopback_strobe_gating,
  output logic             gate_training_start,
  output logic             gate_force_on,
  output logic      [7:0]  rdqs_delay,
  output logic             io_loopback_point,
  output logic             io_oe_force,
  // vt, macro reset, low fields, impedance clock
  output logic             vt_calc_enable,
  output logic             highspeed_macro_reset_n,
  output logic      [31:0] low_fields,
  output logic             impedance_clock
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic           lb_en_q;
  lb_gate_t       lb_gate_q;
  logic           lb_shift_q;
  logic           io_lb_q;
  logic           vt_inh_q;
  logic           hs_bit_q;
  zdiv_t          zdiv_q;
  logic [31:0]    low_q;
  hs_state_t      hs_state_q;
  logic           lb_en_dly_q;
  logic           wr_dly_q;
  logic           wr_hit;
  logic           rd_hit;
  logic [31:0]    cfg_word;
  zclk_if         zc ();

  // write strobe aimed at the mapped word
  assign wr_hit = reg_we && (reg_addr == `CFG1_OFFSET);
  // read strobe aimed at the mapped word
  assign rd_hit = reg_re && (reg_addr == `CFG1_OFFSET);

  // assemble the readable word
  always_comb begin
    cfg_word = low_q & `CFG1_LOW_MASK;
    cfg_word[`CFG1_LB_EN_BIT] = lb_en_q;
    cfg_word[`CFG1_LB_GATE_HI:`CFG1_LB_GATE_LO] = lb_gate_q;
    cfg_word[`CFG1_LB_SHIFT] = lb_shift_q;
    cfg_word[`CFG1_IO_LB_BIT] = io_lb_q;
    cfg_word[`CFG1_VT_INH_BIT] = vt_inh_q;
    cfg_word[`CFG1_HS_RST_BIT] = hs_bit_q;
    cfg_word[`CFG1_ZDIV_HI:`CFG1_ZDIV_LO] = zdiv_q;
  end

  // ------------------------------------------------------------
  // software writes
  // ------------------------------------------------------------
  // loopback controls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lb_en_q    <= 1'b0;
      lb_gate_q  <= gate_always_on;
      lb_shift_q <= 1'b0;
      io_lb_q    <= 1'b0;
    end else if (wr_hit) begin
      lb_en_q    <= reg_wdata[`CFG1_LB_EN_BIT];
      lb_gate_q  <= lb_gate_t'(reg_wdata[`CFG1_LB_GATE_HI:`CFG1_LB_GATE_LO]);
      lb_shift_q <= reg_wdata[`CFG1_LB_SHIFT];
      io_lb_q    <= reg_wdata[`CFG1_IO_LB_BIT];
    end
  end

  // vt inhibit, divider select and the lower fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vt_inh_q <= 1'b0;
      zdiv_q   <= zdiv_32;
      low_q    <= `CFG1_LOW_RESET;
    end else if (wr_hit) begin
      vt_inh_q <= reg_wdata[`CFG1_VT_INH_BIT];
      zdiv_q   <= zdiv_t'(reg_wdata[`CFG1_ZDIV_HI:`CFG1_ZDIV_LO]);
      low_q    <= reg_wdata & `CFG1_LOW_MASK;
    end
  end

  // macro reset bit: only software changes it, never self-clears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_bit_q <= 1'b0;
    end else if (wr_hit) begin
      hs_bit_q <= reg_wdata[`CFG1_HS_RST_BIT];
    end
  end

  // macro reset state: held while bit is zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_state_q <= rst_held;
    end else begin
      case (hs_state_q)
        rst_held:    if (hs_bit_q) hs_state_q <= rst_release;
        rst_release: if (!hs_bit_q) hs_state_q <= rst_held;
        default:     hs_state_q <= rst_held;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (rd_hit) begin
      reg_rdata <= cfg_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // control outputs, all registered
  // ------------------------------------------------------------
  // loopback mode and strobe gating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loopback_enable        <= 1'b0;
      loopback_strobe_gating <= 2'h0;
      gate_force_on          <= 1'b0;
    end else begin
      loopback_enable        <= lb_en_q;
      loopback_strobe_gating <= lb_gate_q;
      gate_force_on          <= lb_en_q && (lb_gate_q == gate_always_on);
    end
  end

  // history of loopback entry and of the last write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lb_en_dly_q <= 1'b0;
      wr_dly_q    <= 1'b0;
    end else begin
      lb_en_dly_q <= lb_en_q;
      wr_dly_q    <= wr_hit; // judged against the fields it wrote
    end
  end

  // training pulse on loopback entry or after a write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_training_start <= 1'b0;
    end else begin
      gate_training_start <= lb_en_q && (lb_gate_q == gate_training) &&
                             (!lb_en_dly_q || wr_dly_q);
    end
  end

  // read strobe delay, zero in loopback unless software shifts
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdqs_delay <= 8'h00;
    end else begin
      rdqs_delay <= (lb_en_q && !lb_shift_q) ? 8'h00 : sw_rdqs_delay;
    end
  end

  // io loopback point and output enable force
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_loopback_point <= 1'b0;
      io_oe_force       <= 1'b0;
    end else begin
      io_loopback_point <= io_lb_q;
      io_oe_force       <= lb_en_q && !io_lb_q;
    end
  end

  // vt calculation only after init and while not inhibited
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vt_calc_enable <= 1'b0;
    end else begin
      vt_calc_enable <= init_done && !vt_inh_q;
    end
  end

  // macro reset follows the state, control logic untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      highspeed_macro_reset_n <= 1'b0;
    end else begin
      highspeed_macro_reset_n <= (hs_state_q == rst_release);
    end
  end

  // stored low fields and divided impedance clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_fields      <= 32'h0000_0000;
      impedance_clock <= 1'b0;
    end else begin
      low_fields      <= low_q;
      impedance_clock <= zc.tick;
    end
  end

  assign zc.sel = zdiv_q;

  zclk_divider u_zdiv (
    .clock (clock),
    .rst_n (rst_n),
    .zc    (zc.div)
  );
endmodule
`default_nettype wire

// *** rtl/phy_cfg_map.svh ***
// offsets, field positions, reset values and divider counts of the loopback/reset config
`ifndef PHY_CFG_MAP_SVH
`define PHY_CFG_MAP_SVH
`define CFG1_OFFSET      8'h00
`define CFG1_LB_EN_BIT   31
`define CFG1_LB_GATE_HI  30
`define CFG1_LB_GATE_LO  29
`define CFG1_LB_SHIFT    28
`define CFG1_IO_LB_BIT   27
`define CFG1_VT_INH_BIT  26
`define CFG1_HS_RST_BIT  25
`define CFG1_ZDIV_HI     24
`define CFG1_ZDIV_LO     23
`define CFG1_LOW_MASK    32'h007f_ffc7
`define CFG1_LOW_RESET   32'h0000_c403
`define CFG1_RESET       32'h0100_c403
`define ZDIV_HALF_2      7'h00
`define ZDIV_HALF_8      7'h03
`define ZDIV_HALF_32     7'h0f
`define ZDIV_HALF_64     7'h1f
`endif

// *** rtl/phy_cfg_pkg.sv ***
// types shared by the loopback/reset configuration block
package phy_cfg_pkg;
  typedef enum logic [1:0] {
    gate_always_on = 2'h0,
    gate_training  = 2'h1,
    gate_manual    = 2'h2,
    gate_reserved  = 2'h3
  } lb_gate_t;
  typedef enum logic [1:0] {
    zdiv_2  = 2'h0,
    zdiv_8  = 2'h1,
    zdiv_32 = 2'h2,
    zdiv_64 = 2'h3
  } zdiv_t;
  typedef enum logic [1:0] {
    rst_held    = 2'b01,
    rst_release = 2'b10
  } hs_state_t;
endpackage

// *** rtl/zclk_if.sv ***
// interface carrying the impedance clock divider setting and its divided clock
`timescale 1ns/1ps
`default_nettype none
interface zclk_if;
  import phy_cfg_pkg::*;
  zdiv_t sel;
  logic  tick;
  modport ctrl (output sel, input tick);
  modport div  (input sel, output tick);
endinterface
`default_nettype wire

// *** rtl/zclk_divider.sv ***
// divider making the impedance-logic divided clock from the controller clock
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_map.svh"
module zclk_divider
  import phy_cfg_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  zclk_if.div       zc
);
  logic [6:0] cnt_q;
  logic [6:0] half_d;
  logic       tick_q;

  // half period count for the selected ratio
  always_comb begin
    case (zc.sel)
      zdiv_2:  half_d = `ZDIV_HALF_2;
      zdiv_8:  half_d = `ZDIV_HALF_8;
      zdiv_32: half_d = `ZDIV_HALF_32;
      zdiv_64: half_d = `ZDIV_HALF_64;
      default: half_d = `ZDIV_HALF_8;
    endcase
  end

  // toggle divided clock each half period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= half_d) begin
      cnt_q  <= 7'h00;
      tick_q <= ~tick_q;
    end else begin
      cnt_q  <= cnt_q + 7'h01;
    end
  end

  assign zc.tick = tick_q;
endmodule
`default_nettype wire

// *** test/phy_cfg_properties.sv ***
// port assertions for the loopback/reset config register
`timescale 1ns/1ps
`default_nettype none
module phy_cfg_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic        init_done,
  input wire logic        loopback_enable,
  input wire logic [1:0]  loopback_strobe_gating,
  input wire logic        gate_force_on,
  input wire logic        io_loopback_point,
  input wire logic        io_oe_force,
  input wire logic        vt_calc_enable,
  input wire logic        highspeed_macro_reset_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // mapped write strobe
  wire logic wr0 = reg_we && reg_addr == 8'h00;
  chk_read_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_read_unmapped: assert property (reg_re && reg_addr != 8'h00 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_loop_follow: assert property (wr0 |=> ##1 loopback_enable == $past(reg_wdata[31], 2))
    else $error("loopback enable not following write");
  chk_gate_force: assert property (gate_force_on == (loopback_enable && loopback_strobe_gating == 2'h0))
    else $error("gate force wrong");
  chk_oe_force: assert property (io_oe_force == (loopback_enable && !io_loopback_point))
    else $error("output enable force wrong");
  chk_vt_gate: assert property (vt_calc_enable |-> $past(init_done))
    else $error("vt calc enabled without init");
  chk_macro_hold: assert property ($fell(highspeed_macro_reset_n) |-> $past(wr0 && !reg_wdata[25], 3))
    else $error("macro reset asserted without write of zero");
  chk_macro_release: assert property ($rose(highspeed_macro_reset_n) |-> $past(wr0 && reg_wdata[25], 3))
    else $error("macro reset released without write of one");
endmodule
bind phy_loopback_reset_config phy_cfg_props chk_u (.clock, .rst_n, .reg_addr, .reg_wdata,
  .reg_we, .reg_re, .reg_rdata, .init_done, .loopback_enable, .loopback_strobe_gating,
  .gate_force_on, .io_loopback_point, .io_oe_force, .vt_calc_enable, .highspeed_macro_reset_n);
`default_nettype wire

// *** test/phy_loopback_reset_config_bench.sv ***
// self-checking bench for the loopback/reset config register
`timescale 1ns/1ps
`default_nettype none
module phy_loopback_reset_config_bench;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [7:0]  sw_rdqs_delay = 8'h5a;
  logic        init_done = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] low_fields;
  logic [1:0]  loopback_strobe_gating;
  logic [7:0]  rdqs_delay;
  logic        loopback_enable, gate_training_start, gate_force_on, io_loopback_point;
  logic        io_oe_force, vt_calc_enable, highspeed_macro_reset_n, impedance_clock;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;
  phy_loopback_reset_config dut_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .sw_rdqs_delay, .init_done, .loopback_enable, .loopback_strobe_gating,
    .gate_training_start, .gate_force_on, .rdqs_delay, .io_loopback_point, .io_oe_force,
    .vt_calc_enable, .highspeed_macro_reset_n, .low_fields, .impedance_clock);
  // clock and hang watchdog
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // upper nine bits over the low fields at their reset values
  function automatic logic [31:0] cfg(input logic [8:0] hi);
    return {hi, 23'h00_c403};
  endfunction
  // edges between two toggles of the impedance clock
  task automatic zhalf(input int e);
    logic p;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      p = impedance_clock;
      while (impedance_clock === p && n < 200) begin
        step(1);
        n++;
      end
    end
    chk(n, e);
  endtask
  // main sequence
  initial begin
    int g;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    step(1);
    chk(highspeed_macro_reset_n, 0);
    chk(low_fields, 32'h0000_c403);
    rd(8'h00, 32'h0100_c403);
    zhalf(16);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    chk(low_fields, 32'h0000_c403);
    rd(8'h00, 32'h0100_c403);
    wr(8'h00, 32'h017f_ffff);
    step(2);
    chk(low_fields, 32'h007f_ffc7);
    chk(highspeed_macro_reset_n, 0);
    rd(8'h00, 32'h017f_ffc7);
    for (g = 0; g < 4; g++) begin
      n = 0;
      wr(8'h00, cfg({1'b1, g[1:0], 6'b000_101}));
      repeat (4) begin
        step(1);
        n += gate_training_start;
      end
      chk(n, g == 1);
      chk(gate_force_on, g == 0);
      chk(loopback_strobe_gating, g);
      chk(loopback_enable, 1);
      chk(rdqs_delay, 0);
      chk(io_oe_force, 1);
    end
    rd(8'h00, cfg(9'b1_11_000_101));
    wr(8'h00, cfg(9'b1_10_110_101));
    step(2);
    chk(rdqs_delay, 8'h5a);
    chk(io_oe_force, 0);
    chk(io_loopback_point, 1);
    wr(8'h00, cfg(9'b0_00_000_101));
    step(2);
    chk(loopback_enable, 0);
    chk(rdqs_delay, 8'h5a);
    chk(vt_calc_enable, 0);
    @(posedge clock);
    init_done <= 1'b1;
    step(2);
    chk(vt_calc_enable, 1);
    wr(8'h00, cfg(9'b0_00_001_101));
    step(2);
    chk(vt_calc_enable, 0);
    wr(8'h00, cfg(9'b0_00_000_001));
    step(20);
    chk(highspeed_macro_reset_n, 0);
    rd(8'h00, cfg(9'b0_00_000_001));
    wr(8'h00, cfg(9'b0_00_000_101));
    step(1);
    chk(highspeed_macro_reset_n, 0);
    step(1);
    chk(highspeed_macro_reset_n, 1);
    for (g = 0; g < 4; g++) begin
      wr(8'h00, cfg({7'b0_00_0001, g[1:0]}));
      step(70);
      zhalf(g == 0 ? 1 : g == 1 ? 4 : g == 2 ? 16 : 32);
    end
    wr(8'h00, cfg(9'b0_00_000_101));
    rd(8'h00, cfg(9'b0_00_000_101));
    zhalf(4);
    print_verdict();
  end
endmodule
`default_nettype wire
